// *** tep_map.vh ***
`ifndef TEP_MAP_VH
`define TEP_MAP_VH
// Mode register index and its byte address on the bus.
`define TEP_MODE_IDX 12'h336
`define TEP_MODE_ADDR 12'hcd8
`define TEP_RELOAD_ADDR 12'h000
`define TEP_EXTA_ADDR 12'h004
`define TEP_EXTB_ADDR 12'h008
`define TEP_EXTC_ADDR 12'h00c
`define TEP_CTRL_ADDR 12'h010
`define TEP_STAT_ADDR 12'h014
// Mode register fields.
`define TEP_MODE_SRC_HI 7
`define TEP_MODE_SRC_LO 6
`define TEP_MODE_W8 5
`define TEP_MODE_TSEL 4
`define TEP_MODE_EDGE 3
`define TEP_MODE_RST 8'h00
// Control register fields.
`define TEP_CTRL_RUN 0
`define TEP_CTRL_PCLK 1
`define TEP_CTRL_RT_HI 3
`define TEP_CTRL_RT_LO 2
`define TEP_CTRL_RST 8'h00
`define TEP_EXT_RST 8'h00
`define TEP_RELOAD_RST 16'h0000
// Status register fields.
`define TEP_STAT_IRQ 0
`define TEP_STAT_OUT 1
// Low phase length base: one period is 255 prescaler expiries.
`define TEP_PERIOD_UNITS 8'hff
`define TEP_SUB_DIV 5'h1f
`define TEP_RESP_OKAY 2'b00
`define TEP_RESP_SLVERR 2'b10
`endif

// *** tep_pwm.v ***
// Behaviour
// - With run set, trigger falling edge starts down count; output goes high after the low lead.
// - End of high time drives output low, unless the high byte is 255, and sets the interrupt request bit.
// - Each full pulse cycle reloads the counter from the reload register.
// - Clearing run stops the counter, holds its value, forces output low.
// - Period is (m+1) times 255 count-source periods.
// - High width is n times (m+1) count-source periods.
// - High byte zero: no run, output low, no interrupt request.
// - After each start from idle output first stays low for the high width.
// - Mode source field 00 fast, 01 div8, 10 div32, 11 sub-clock div32.
// - Mode source field applies only while extended enable bit is 0.
// - Extended enable 1: lower three bits choose among six count sources.
// - Extended registers hold even channel low nibble, odd channel high nibble; channels 4 and up all use the low nibble of C.
// - Fast source is peripheral clock when select is 1, else halved.
// - Width-select bit 1 makes the channel an 8-bit modulator with prescaler.
// - Trigger-select 1 takes routed start; edge bit 0 picks falling edge.
// - Edge selection applies only when routing field selects the pin.
// - Start may also come from neighbour channel overflow or second timer.
`timescale 1ns/10ps
`include "tep_map.vh"
module tep_pwm #(
   parameter CHANNEL = 0
) (
   input wire mclk,
   input wire sys_rst,
   input wire ce,
   input wire trigger_input_pin,
   input wire subclock_pin,
   input wire slow_osc_pin,
   input wire prev_channel_ovf,
   input wire next_channel_ovf,
   input wire timer_b_ovf,
   output reg waveform_output_pin,
   output reg overflow_pulse,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output reg s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output reg s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [11:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output reg s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready
);
   localparam ST_IDLE = 4'b0001;
   localparam ST_LEAD = 4'b0010;
   localparam ST_HIGH = 4'b0100;
   localparam ST_LOW = 4'b1000;

   reg [7:0] mode_reg;
   reg [7:0] ext_a_reg;
   reg [7:0] ext_b_reg;
   reg [7:0] ext_c_reg;
   reg [7:0] ctrl_reg;
   reg [15:0] reload_reg;
   reg irq_reg;
   reg [3:0] state_reg;
   reg [7:0] pre_reg;
   reg [7:0] wid_reg;
   reg [7:0] m_reg;
   reg [7:0] n_reg;
   reg [6:0] pdiv_reg;
   reg [4:0] sub_cnt_reg;
   reg trig_s1, trig_s2, trig_s3;
   reg sub_s1, sub_s2, sub_s3;
   reg osc_s1, osc_s2, osc_s3;
   reg run_d_reg;
   reg aw_hold_reg;
   reg w_hold_reg;
   reg [11:0] aw_addr_reg;
   reg [31:0] w_data_reg;
   reg [3:0] w_strb_reg;

   // Count-source taps from the free-running peripheral divider and the synchronised external clocks.
   wire fast_tick = ctrl_reg[`TEP_CTRL_PCLK] | pdiv_reg[0];
   wire div8_tick = (pdiv_reg[2:0] == 3'h7);
   wire div32_tick = (pdiv_reg[4:0] == 5'h1f);
   wire div64_tick = (pdiv_reg[5:0] == 6'h3f);
   wire sub_edge = sub_s2 & ~sub_s3;
   wire subclock_div32 = sub_edge & (sub_cnt_reg == `TEP_SUB_DIV);
   wire osc_tick = osc_s2 & ~osc_s3;

   // Pick this channel's nibble out of the three extended registers.
   reg [3:0] ext_nib;
   always @* begin
      case (CHANNEL)
         0: ext_nib = ext_a_reg[3:0];
         1: ext_nib = ext_a_reg[7:4];
         2: ext_nib = ext_b_reg[3:0];
         3: ext_nib = ext_b_reg[7:4];
         default: ext_nib = ext_c_reg[3:0];
      endcase
   end

   // Codes 100 and 111 are reserved and give no count at all.
   reg tick;
   always @* begin
      tick = 1'b0;
      if (!ext_nib[3]) begin
         case (mode_reg[`TEP_MODE_SRC_HI:`TEP_MODE_SRC_LO])
            2'b00: tick = fast_tick;
            2'b01: tick = div8_tick;
            2'b10: tick = div32_tick;
            default: tick = subclock_div32;
         endcase
      end else begin
         case (ext_nib[2:0])
            3'b000: tick = fast_tick;
            3'b001: tick = div8_tick;
            3'b010: tick = div32_tick;
            3'b011: tick = div64_tick;
            3'b101: tick = osc_tick;
            3'b110: tick = subclock_div32;
            default: tick = 1'b0;
         endcase
      end
   end

   // Start event: routed source, or a software start when routing is off.
   wire run = ctrl_reg[`TEP_CTRL_RUN];
   wire [1:0] route = ctrl_reg[`TEP_CTRL_RT_HI:`TEP_CTRL_RT_LO];
   wire pin_edge = mode_reg[`TEP_MODE_EDGE] ? (trig_s2 & ~trig_s3) : (trig_s3 & ~trig_s2);
   reg routed;
   always @* begin
      case (route)
         2'b00: routed = pin_edge;
         2'b01: routed = timer_b_ovf;
         2'b10: routed = prev_channel_ovf;
         default: routed = next_channel_ovf;
      endcase
   end
   wire start_evt = mode_reg[`TEP_MODE_TSEL] ? routed : (run & ~run_d_reg);
   wire enabled = run & mode_reg[`TEP_MODE_W8];
   wire pre_done = tick & (pre_reg == 8'h00);
   wire wid_last = pre_done & (wid_reg == 8'h01);
   wire [7:0] low_len = `TEP_PERIOD_UNITS - n_reg;

   // Synchronisers and the divider for the external clocks and trigger.
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         trig_s1 <= 1'b1;
         trig_s2 <= 1'b1;
         trig_s3 <= 1'b1;
         sub_s1 <= 1'b0;
         sub_s2 <= 1'b0;
         sub_s3 <= 1'b0;
         osc_s1 <= 1'b0;
         osc_s2 <= 1'b0;
         osc_s3 <= 1'b0;
         pdiv_reg <= 7'h00;
         sub_cnt_reg <= 5'h00;
         run_d_reg <= 1'b0;
      end else if (ce) begin
         trig_s1 <= trigger_input_pin;
         trig_s2 <= trig_s1;
         trig_s3 <= trig_s2;
         sub_s1 <= subclock_pin;
         sub_s2 <= sub_s1;
         sub_s3 <= sub_s2;
         osc_s1 <= slow_osc_pin;
         osc_s2 <= osc_s1;
         osc_s3 <= osc_s2;
         pdiv_reg <= pdiv_reg + 7'h01;
         if (sub_edge) begin
            sub_cnt_reg <= sub_cnt_reg + 5'h01;
         end
         run_d_reg <= run;
      end
   end

   // Modulator: lead low, high for n units, low for 255-n units, repeat.
   // A high byte of 255 leaves no low phase, so the output then stays high.
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         state_reg <= ST_IDLE;
         pre_reg <= 8'h00;
         wid_reg <= 8'h00;
         m_reg <= 8'h00;
         n_reg <= 8'h00;
         waveform_output_pin <= 1'b0;
         overflow_pulse <= 1'b0;
      end else if (ce) begin
         overflow_pulse <= 1'b0;
         if (!enabled) begin
            state_reg <= ST_IDLE;
            waveform_output_pin <= 1'b0;
         end else begin
            case (state_reg)
               ST_IDLE: begin
                  waveform_output_pin <= 1'b0;
                  if (start_evt && reload_reg[15:8] != 8'h00) begin
                     m_reg <= reload_reg[7:0];
                     n_reg <= reload_reg[15:8];
                     pre_reg <= reload_reg[7:0];
                     wid_reg <= reload_reg[15:8];
                     state_reg <= ST_LEAD;
                  end
               end
               ST_LEAD: begin
                  if (pre_done) begin
                     pre_reg <= m_reg;
                     wid_reg <= wid_reg - 8'h01;
                  end else if (tick) begin
                     pre_reg <= pre_reg - 8'h01;
                  end
                  if (wid_last) begin
                     wid_reg <= n_reg;
                     waveform_output_pin <= 1'b1;
                     state_reg <= ST_HIGH;
                  end
               end
               ST_HIGH: begin
                  if (pre_done) begin
                     pre_reg <= m_reg;
                     wid_reg <= wid_reg - 8'h01;
                  end else if (tick) begin
                     pre_reg <= pre_reg - 8'h01;
                  end
                  if (wid_last) begin
                     if (n_reg == `TEP_PERIOD_UNITS) begin
                        overflow_pulse <= 1'b1;
                        m_reg <= reload_reg[7:0];
                        n_reg <= reload_reg[15:8];
                        pre_reg <= reload_reg[7:0];
                        wid_reg <= reload_reg[15:8];
                        if (reload_reg[15:8] == 8'h00) begin
                           waveform_output_pin <= 1'b0;
                           state_reg <= ST_IDLE;
                        end
                     end else begin
                        waveform_output_pin <= 1'b0;
                        wid_reg <= low_len;
                        state_reg <= ST_LOW;
                     end
                  end
               end
               ST_LOW: begin
                  if (pre_done) begin
                     pre_reg <= m_reg;
                     wid_reg <= wid_reg - 8'h01;
                  end else if (tick) begin
                     pre_reg <= pre_reg - 8'h01;
                  end
                  if (wid_last) begin
                     overflow_pulse <= 1'b1;
                     m_reg <= reload_reg[7:0];
                     n_reg <= reload_reg[15:8];
                     pre_reg <= reload_reg[7:0];
                     wid_reg <= reload_reg[15:8];
                     if (reload_reg[15:8] == 8'h00) begin
                        state_reg <= ST_IDLE;
                     end else begin
                        waveform_output_pin <= 1'b1;
                        state_reg <= ST_HIGH;
                     end
                  end
               end
               default: state_reg <= ST_IDLE;
            endcase
         end
      end
   end

   // The request is raised at the end of each high phase, even when a high byte of 255 keeps the output high.
   wire irq_set = ce & enabled & (state_reg == ST_HIGH) & wid_last & (n_reg != `TEP_PERIOD_UNITS);
   wire irq_set_full = ce & enabled & (state_reg == ST_HIGH) & wid_last & (n_reg == `TEP_PERIOD_UNITS);

   // AXI4-Lite write side; address and data may arrive in either order.
   wire do_write = aw_hold_reg & w_hold_reg & ~s_axi_bvalid;
   wire [9:0] wa = aw_addr_reg[11:2];
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         aw_hold_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_addr_reg <= 12'h000;
         w_data_reg <= 32'h00000000;
         w_strb_reg <= 4'h0;
         s_axi_awready <= 1'b0;
         s_axi_wready <= 1'b0;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= `TEP_RESP_OKAY;
         mode_reg <= `TEP_MODE_RST;
         ext_a_reg <= `TEP_EXT_RST;
         ext_b_reg <= `TEP_EXT_RST;
         ext_c_reg <= `TEP_EXT_RST;
         ctrl_reg <= `TEP_CTRL_RST;
         reload_reg <= `TEP_RELOAD_RST;
         irq_reg <= 1'b0;
      end else if (ce) begin
         s_axi_awready <= ~aw_hold_reg & ~s_axi_awready & ~s_axi_bvalid;
         s_axi_wready <= ~w_hold_reg & ~s_axi_wready & ~s_axi_bvalid;
         if (s_axi_awvalid && s_axi_awready) begin
            aw_hold_reg <= 1'b1;
            aw_addr_reg <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
         end
         if (s_axi_wvalid && s_axi_wready) begin
            w_hold_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
         end
         if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
         end
         if (irq_set || irq_set_full) begin
            irq_reg <= 1'b1;
         end else if (do_write && wa == `TEP_STAT_ADDR >> 2 && w_strb_reg[0]
                      && w_data_reg[`TEP_STAT_IRQ]) begin
            irq_reg <= 1'b0;
         end
         if (do_write) begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= `TEP_RESP_OKAY;
            if (wa == `TEP_MODE_ADDR >> 2) begin
               if (w_strb_reg[0]) mode_reg <= w_data_reg[7:0];
            end else if (wa == `TEP_RELOAD_ADDR >> 2) begin
               if (w_strb_reg[0]) reload_reg[7:0] <= w_data_reg[7:0];
               if (w_strb_reg[1]) reload_reg[15:8] <= w_data_reg[15:8];
            end else if (wa == `TEP_EXTA_ADDR >> 2) begin
               if (w_strb_reg[0]) ext_a_reg <= w_data_reg[7:0];
            end else if (wa == `TEP_EXTB_ADDR >> 2) begin
               if (w_strb_reg[0]) ext_b_reg <= w_data_reg[7:0];
            end else if (wa == `TEP_EXTC_ADDR >> 2) begin
               if (w_strb_reg[0]) ext_c_reg <= w_data_reg[7:0];
            end else if (wa == `TEP_CTRL_ADDR >> 2) begin
               if (w_strb_reg[0]) ctrl_reg <= w_data_reg[7:0];
            end else if (wa != `TEP_STAT_ADDR >> 2) begin
               s_axi_bresp <= `TEP_RESP_SLVERR;
            end
         end
      end
   end

   // AXI4-Lite read side; the status word also shows the live counter.
   wire [9:0] ra = s_axi_araddr[11:2];
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         s_axi_arready <= 1'b0;
         s_axi_rvalid <= 1'b0;
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= `TEP_RESP_OKAY;
      end else if (ce) begin
         s_axi_arready <= ~s_axi_arready & ~s_axi_rvalid;
         if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
         end
         if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rresp <= `TEP_RESP_OKAY;
            s_axi_rdata <= 32'h00000000;
            if (ra == `TEP_MODE_ADDR >> 2) begin
               s_axi_rdata <= {24'h000000, mode_reg};
            end else if (ra == `TEP_RELOAD_ADDR >> 2) begin
               s_axi_rdata <= {16'h0000, reload_reg};
            end else if (ra == `TEP_EXTA_ADDR >> 2) begin
               s_axi_rdata <= {24'h000000, ext_a_reg};
            end else if (ra == `TEP_EXTB_ADDR >> 2) begin
               s_axi_rdata <= {24'h000000, ext_b_reg};
            end else if (ra == `TEP_EXTC_ADDR >> 2) begin
               s_axi_rdata <= {24'h000000, ext_c_reg};
            end else if (ra == `TEP_CTRL_ADDR >> 2) begin
               s_axi_rdata <= {24'h000000, ctrl_reg};
            end else if (ra == `TEP_STAT_ADDR >> 2) begin
               s_axi_rdata <= {8'h00, wid_reg, pre_reg, 6'h00, waveform_output_pin, irq_reg};
            end else begin
               s_axi_rresp <= `TEP_RESP_SLVERR;
            end
         end
      end
   end
endmodule

// *** tep_pwm_props.sv ***
`timescale 1ns/10ps
`include "tep_map.vh"
module tep_pwm_props (
   input wire mclk,
   input wire sys_rst,
   input wire waveform_output_pin,
   input wire overflow_pulse,
   input wire [11:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire [1:0] s_axi_bresp,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire [31:0] s_axi_rdata,
   input wire s_axi_rvalid,
   input wire s_axi_rready
);
   reg [7:0] mode_q;
   reg [7:0] ctrl_q;
   reg [3:0] ext_q;
   reg [15:0] rel_q;
   reg [16:0] ph_cnt;
   reg [16:0] per_cnt;
   reg wave_d;
   reg fell_seen;
   reg ovf_seen;
   wire wr_go = s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
   wire [16:0] unit = {9'h000, rel_q[7:0]} + 17'h00001;
   wire [16:0] n_w = {9'h000, rel_q[15:8]};
   wire timed = ctrl_q[0] && ctrl_q[1] && mode_q[7:6] == 2'b00 && !ext_q[3];
   // Shadow of the configuration; it sees only writes whose address and data go in together.
   // Timing checks hold only for the undivided source, where one tick is one clock.
   always @(posedge mclk or posedge sys_rst) begin
      if (sys_rst) begin
         mode_q <= 8'h00;
         ctrl_q <= 8'h00;
         ext_q <= 4'h0;
         rel_q <= 16'h0000;
         ph_cnt <= 17'h00000;
         per_cnt <= 17'h00000;
         wave_d <= 1'b0;
         fell_seen <= 1'b0;
         ovf_seen <= 1'b0;
      end else begin
         if (wr_go && s_axi_awaddr == `TEP_MODE_ADDR) mode_q <= s_axi_wdata[7:0];
         if (wr_go && s_axi_awaddr == `TEP_CTRL_ADDR) ctrl_q <= s_axi_wdata[7:0];
         if (wr_go && s_axi_awaddr == `TEP_EXTA_ADDR) ext_q <= s_axi_wdata[3:0];
         if (wr_go && s_axi_awaddr == `TEP_RELOAD_ADDR) rel_q <= s_axi_wdata[15:0];
         wave_d <= waveform_output_pin;
         ph_cnt <= (waveform_output_pin != wave_d) ? 17'h00001 : ph_cnt + 17'h00001;
         per_cnt <= overflow_pulse ? 17'h00001 : per_cnt + 17'h00001;
         fell_seen <= ctrl_q[0] && (fell_seen || (wave_d && !waveform_output_pin));
         ovf_seen <= ctrl_q[0] && (ovf_seen || overflow_pulse);
      end
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (sys_rst);
   AST_WRESP: assert property (wr_go |-> ##[1:3] s_axi_bvalid)
      else $error("write response missing");
   AST_RRESP: assert property (s_axi_arvalid && s_axi_arready |-> ##[1:2] s_axi_rvalid)
      else $error("read response missing");
   AST_BHOLD: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
   AST_RHOLD: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
   AST_ARBLK: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken while answer pending");
   AST_OVF: assert property (overflow_pulse |=> !overflow_pulse)
      else $error("overflow pulse too long");
   AST_STOP: assert property (!ctrl_q[0] && !$past(ctrl_q[0], 2) |-> !waveform_output_pin)
      else $error("output high while stopped");
   AST_HIGH: assert property ($fell(waveform_output_pin) && timed |-> ph_cnt == n_w * unit)
      else $error("high width wrong");
   AST_GAP: assert property ($rose(waveform_output_pin) && timed && fell_seen |->
      ph_cnt == (17'h000ff - n_w) * unit)
      else $error("low gap wrong");
   AST_PERIOD: assert property (overflow_pulse && timed && ovf_seen |-> per_cnt == 17'h000ff * unit)
      else $error("period wrong");
endmodule
bind tep_pwm tep_pwm_props u_props (.mclk(mclk), .sys_rst(sys_rst),
   .waveform_output_pin(waveform_output_pin), .overflow_pulse(overflow_pulse),
   .s_axi_awaddr(s_axi_awaddr), .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
   .s_axi_wdata(s_axi_wdata), .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
   .s_axi_bresp(s_axi_bresp), .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
   .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready), .s_axi_rdata(s_axi_rdata),
   .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready));

// *** tep_load_model.sv ***
`timescale 1ns/10ps
module tep_load_model (
   input wire mclk,
   input wire waveform_output_pin,
   output reg trigger_input_pin,
   output reg subclock_pin,
   output reg slow_osc_pin
);
   integer hi_w, per, lead, rises, falls, ph_cnt, per_cnt, lead_cnt;
   reg wave_d, trig_d;
   reg [2:0] div;
   // The trigger pin idles high, so only a deliberate pulse gives a falling edge.
   initial begin
      trigger_input_pin = 1'b1;
      {subclock_pin, slow_osc_pin, wave_d, div} = 6'h00;
      trig_d = 1'b1;
      {hi_w, per, lead, rises, falls, ph_cnt, per_cnt, lead_cnt} = 256'h0;
   end
   task trig_fall;
      @(posedge mclk);
      trigger_input_pin <= 1'b0;
      repeat (4) @(posedge mclk);
      trigger_input_pin <= 1'b1;
   endtask
   // Oscillators run free: sub-clock rises every 4 cycles, slow one every 8.
   // Widths are whole clock cycles, so a one-cycle slip in the block shows up.
   always @(posedge mclk) begin
      div <= div + 3'h1;
      subclock_pin <= div[1];
      slow_osc_pin <= div[2];
      wave_d <= waveform_output_pin;
      trig_d <= trigger_input_pin;
      ph_cnt <= (waveform_output_pin != wave_d) ? 1 : ph_cnt + 1;
      per_cnt <= per_cnt + 1;
      lead_cnt <= lead_cnt + 1;
      if (trig_d && !trigger_input_pin) lead_cnt <= 1;
      if (waveform_output_pin && !wave_d) begin
         rises <= rises + 1;
         per <= per_cnt;
         per_cnt <= 1;
         lead <= lead_cnt;
      end
      if (!waveform_output_pin && wave_d) begin
         falls <= falls + 1;
         hi_w <= ph_cnt;
      end
   end
endmodule

// *** test_tep_pwm.sv ***
`timescale 1ns/10ps
`include "tep_map.vh"
module test_tep_pwm;
   // Rows: mode, extended nibbles, control, clock cycles per count-source period.
   localparam [31:0] CFG [0:11] = '{32'h27000301, 32'h27000102, 32'h67000308, 32'ha7000320,
      32'he7000380, 32'he7080301, 32'h27090308, 32'h270a0320, 32'h270b0340, 32'h270d0308,
      32'h270e0380, 32'ha7b00320};
   reg mclk, sys_rst, awvalid, wvalid, bready, arvalid, rready;
   reg [2:0] ev;
   reg [11:0] awaddr, araddr;
   reg [31:0] wdata, rd_val, st_a;
   reg [1:0] resp;
   wire awready, wready, bvalid, arready, rvalid, wave, trig, sub_clk, slow_clk;
   wire [1:0] bresp, rresp;
   wire [31:0] rdata;
   integer errors, checked, i, r;
   tep_pwm #(.CHANNEL(0)) uut (.mclk(mclk), .sys_rst(sys_rst), .ce(1'b1),
      .trigger_input_pin(trig), .subclock_pin(sub_clk), .slow_osc_pin(slow_clk),
      .prev_channel_ovf(ev[1]), .next_channel_ovf(ev[2]), .timer_b_ovf(ev[0]),
      .waveform_output_pin(wave), .overflow_pulse(), .s_axi_awaddr(awaddr),
      .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
      .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
      .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
      .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
      .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready));
   tep_load_model partner (.mclk(mclk), .waveform_output_pin(wave),
      .trigger_input_pin(trig), .subclock_pin(sub_clk), .slow_osc_pin(slow_clk));
   task chk(input [8*12-1:0] name, input [31:0] exp, input [31:0] got);
      checked = checked + 1;
      if (exp !== got) begin
         errors = errors + 1;
         $display("[ERR] %0s expected %h seen %h", name, exp, got);
      end
   endtask
   // Address and data are offered together; each is dropped the edge it is taken.
   task wr(input [11:0] a, input [31:0] d);
      reg aw_ok, w_ok;
      @(posedge mclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      {aw_ok, w_ok} = 2'b00;
      while (!(aw_ok && w_ok)) begin
         @(posedge mclk);
         if (!aw_ok && awready) begin
            aw_ok = 1'b1;
            awvalid <= 1'b0;
         end
         if (!w_ok && wready) begin
            w_ok = 1'b1;
            wvalid <= 1'b0;
         end
      end
      while (!bvalid) @(posedge mclk);
      resp = bresp;
      bready <= 1'b0;
   endtask
   task rd(input [11:0] a, output [31:0] d);
      @(posedge mclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      @(posedge mclk);
      while (!arready) @(posedge mclk);
      arvalid <= 1'b0;
      while (!rvalid) @(posedge mclk);
      d = rdata;
      resp = rresp;
      rready <= 1'b0;
   endtask
   // A stop first, so the rising run bit or the routed event gives a fresh start.
   task start(input [7:0] m, input [7:0] x, input [7:0] c);
      wr(`TEP_CTRL_ADDR, 32'h0);
      wr(`TEP_MODE_ADDR, {24'h0, m});
      wr(`TEP_EXTA_ADDR, {24'h0, x});
      wr(`TEP_CTRL_ADDR, {24'h0, c});
   endtask
   task wait_ev(input integer rise);
      integer c;
      c = rise ? partner.rises : partner.falls;
      while ((rise ? partner.rises : partner.falls) == c) @(posedge mclk);
   endtask
   task conclude;
      $display("checked %0d errors %0d", checked, errors);
      if (errors == 0 && checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   initial begin
      mclk = 1'b0;
      forever #20 mclk = ~mclk;
   end
   // All tests take well under 20000 cycles; a hang is cut off after 50000.
   initial begin
      #2000000;
      errors = errors + 1;
      conclude;
   end
   initial begin
      {sys_rst, awvalid, wvalid, bready, arvalid, rready, ev} = 9'h100;
      {awaddr, araddr, wdata} = 56'h0;
      {errors, checked} = 64'h0;
      repeat (6) @(posedge mclk);
      sys_rst <= 1'b0;
      for (i = 0; i < 6; i = i + 1) begin
         rd({i[9:0], 2'b00}, rd_val);
         chk("reset_val", 32'h0, rd_val);
      end
      rd(`TEP_MODE_ADDR, rd_val);
      chk("mode_reset", 32'h0, rd_val);
      rd(12'h020, rd_val);
      chk("unmap_rd", {30'h0, `TEP_RESP_SLVERR}, {30'h0, resp});
      wr(12'h020, 32'h000000ff);
      chk("unmap_wr", {30'h0, `TEP_RESP_SLVERR}, {30'h0, resp});
      wr(`TEP_EXTB_ADDR, 32'h0000005a);
      rd(`TEP_EXTB_ADDR, rd_val);
      chk("ext_b", 32'h0000005a, rd_val);
      $display("test registers done");
      wr(`TEP_RELOAD_ADDR, 32'h00000301);
      for (i = 0; i < 12; i = i + 1) begin
         start(CFG[i][31:24], CFG[i][23:16], CFG[i][15:8]);
         wait_ev(0);
         chk("high_width", 6 * CFG[i][7:0], partner.hi_w);
      end
      $display("test sources done");
      start(8'h27, 8'h00, 8'h03);
      repeat (3) wait_ev(1);
      chk("period", 32'h000001fe, partner.per);
      wait_ev(0);
      rd(`TEP_STAT_ADDR, rd_val);
      chk("irq_low_out", 32'h1, {30'h0, rd_val[1:0]});
      wr(`TEP_STAT_ADDR, 32'h1);
      rd(`TEP_STAT_ADDR, rd_val);
      chk("irq_clear", 32'h0, {31'h0, rd_val[0]});
      $display("test period done");
      wr(`TEP_RELOAD_ADDR, 32'h0000030f);
      start(8'h27, 8'h00, 8'h03);
      wait_ev(1);
      wr(`TEP_CTRL_ADDR, 32'h2);
      rd(`TEP_STAT_ADDR, st_a);
      repeat (20) @(posedge mclk);
      rd(`TEP_STAT_ADDR, rd_val);
      chk("held_count", {16'h0, st_a[23:8]}, {16'h0, rd_val[23:8]});
      chk("stop_low", 32'h0, {30'h0, wave, rd_val[1]});
      $display("test stop done");
      for (i = 0; i < 2; i = i + 1) begin
         wr(`TEP_RELOAD_ADDR, i ? 32'h00000301 : 32'h00000001);
         wr(`TEP_STAT_ADDR, 32'h1);
         start(i ? 8'h07 : 8'h27, 8'h00, 8'h03);
         r = partner.rises;
         repeat (600) @(posedge mclk);
         chk("no_pulse", r, partner.rises);
         rd(`TEP_STAT_ADDR, rd_val);
         chk("no_irq", 32'h0, {31'h0, rd_val[0]});
      end
      $display("test idle done");
      wr(`TEP_RELOAD_ADDR, 32'h00000301);
      // Lead is three sync edges plus n*(m+1) ticks, counted from the pin's fall.
      // The rising-edge case starts four cycles later, when the pin returns high.
      for (i = 0; i < 2; i = i + 1) begin
         start(i ? 8'h3f : 8'h37, 8'h00, 8'h03);
         r = partner.rises;
         repeat (30) @(posedge mclk);
         chk("wait_trig", r, partner.rises);
         partner.trig_fall;
         wait_ev(1);
         chk("lead_low", i ? 13 : 9, partner.lead);
      end
      for (i = 1; i < 4; i = i + 1) begin
         start(8'h37, 8'h00, {4'h0, i[1:0], 2'b11});
         r = partner.rises;
         @(posedge mclk);
         ev <= 3'b001 << (i - 1);
         @(posedge mclk);
         ev <= 3'b000;
         wait_ev(1);
         chk("routed", r + 1, partner.rises);
      end
      $display("test triggers done");
      conclude;
   end
endmodule
